/* hdl/serial_sync_io_control_brg.sv */
// Notes on behaviour
// - Generator divides the clock by a 16-bit divisor, 2 to 65535.
// - Writing the divisor loads the counter immediately.
// - Divisor of zero or one stops the generator.
// - Sync mode enable clear makes all sync control settings ignored.
// - Input invert affects received data only, not echo or loopback.
// - Receive clock edge select: 0 rising, 1 falling sample edge.
// - Carrier gate enable clocks receiver only while gate input active, except in loopback.
// - Gate polarity: 0 active low, 1 active high; gating only.
// - Input block disables data, receive clock and gate inputs.
// - Echo drives clock out from receive clock, request from gate.
// - Output invert affects transmitted data only.
// - Output idle level: 0 high, 1 low between frames.
// - Transmit clock edge select: 0 rising, 1 falling active edge.
// - Transmit clock idle level: 0 high, 1 low.
// - Request asserted before first active edge, released after last.
// - Frame strobe high during first bit, low from second bit; held low in echo.
// - Request polarity: 0 active low, 1 high; ignored in loopback.
// - Output tristate floats data, clock and request outputs.
// - Partner reads request as frame notice; gate marks partner frame.
// - Echo drives data out from data in; receiver keeps running.
// - Loopback forces data out high, loops transmit into receive.
// - Clock divisor select: 0 sixteen clocks per bit, 1 one.
`include "sio_defines.svh"
module serial_sync_io_control_brg #(
    parameter int unsigned DIV_WIDTH = 16
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        serial_data_in,
    input  wire logic        receive_clock_in,
    input  wire logic        carrier_gate_in,
    output logic             serial_data_out,
    output logic             serial_data_out_oe_n,
    output logic             serial_clock_out,
    output logic             serial_clock_out_oe_n,
    output logic             request_out,
    output logic             request_out_oe_n,
    output logic             frame_start_strobe
);
    logic [DIV_WIDTH-1:0] div_reg;
    sio_pkg::byte_t       sic_reg;
    sio_pkg::byte_t       soc_reg;
    sio_pkg::byte_t       sic_eff;
    sio_pkg::byte_t       soc_eff;
    sio_pkg::byte_t       tx_data_reg;
    sio_pkg::byte_t       tx_shift_reg;
    sio_pkg::byte_t       rx_shift_reg;
    sio_pkg::byte_t       rx_data_reg;
    sio_pkg::tx_state_t   tx_state_reg;
    logic [2:0]           mode_reg;
    logic [2:0]           tx_count_reg;
    logic [2:0]           rx_count_reg;
    logic [3:0]           presc_reg;
    logic [2:0]           pins;
    logic                 load_reg;
    logic                 tx_pend_reg;
    logic                 rx_ready_reg;
    logic                 bclk_q_reg;
    logic                 rxc_q_reg;
    logic                 brg_tick;
    logic                 brg_level;
    logic                 brg_running;
    logic                 echo;
    logic                 loop;
    logic                 one_x;
    logic                 bit_tick;
    logic                 bclk;
    logic                 busy;
    logic                 wr_ok;
    logic                 rd_ok;
    logic                 sin_eff;
    logic                 rxc_eff;
    logic                 gate_active;
    logic                 ext_edge;
    logic                 rx_edge;
    logic                 rx_bit;
    logic                 frame_act;
    logic                 serial_data_out_next;
    logic                 clk_next;
    logic                 req_next;
    logic [7:0]           idx;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    assign idx   = avs_address[9:2];
    assign wr_ok = avs_write && !avs_waitrequest;
    assign rd_ok = avs_read && !avs_waitrequest;

    // Slave answers one cycle after the request is seen
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            unique case (1'b1)
                hit(idx, `IDX_MODE):     avs_readdata <= {29'h0, mode_reg};
                hit(idx, `IDX_TX_DATA):  avs_readdata <= {24'h0, tx_data_reg};
                hit(idx, `IDX_RX_DATA):  avs_readdata <= {24'h0, rx_data_reg};
                hit(idx, `IDX_STATUS):
                    avs_readdata <= {28'h0, frame_act, brg_running, rx_ready_reg, busy};
                hit(idx, `IDX_DIV_HIGH): avs_readdata <= {24'h0, div_reg[15:8]};
                hit(idx, `IDX_DIV_LOW):  avs_readdata <= {24'h0, div_reg[7:0]};
                hit(idx, `IDX_SIC):      avs_readdata <= {24'h0, sic_reg};
                hit(idx, `IDX_SOC):      avs_readdata <= {24'h0, soc_reg};
                default:                 avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div_reg  <= DIV_WIDTH'(`DIV_RESET);
            load_reg <= 1'b0;
        end else begin
            load_reg <= wr_ok && (hit(idx, `IDX_DIV_LOW) || hit(idx, `IDX_DIV_HIGH));
            if (wr_ok && hit(idx, `IDX_DIV_LOW)) begin
                div_reg[7:0] <= avs_writedata[7:0];
            end
            if (wr_ok && hit(idx, `IDX_DIV_HIGH)) begin
                div_reg[15:8] <= avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sic_reg  <= `SIC_RESET;
            soc_reg  <= `SOC_RESET;
            mode_reg <= `MODE_RESET;
        end else if (wr_ok) begin
            if (hit(idx, `IDX_SIC)) begin
                sic_reg <= (avs_writedata[7:0] & ~`SIC_FIXED_MASK) | (`SIC_RESET & `SIC_FIXED_MASK);
            end
            if (hit(idx, `IDX_SOC)) begin
                soc_reg <= (avs_writedata[7:0] & ~`SOC_FIXED_MASK) | (`SOC_RESET & `SOC_FIXED_MASK);
            end
            if (hit(idx, `IDX_MODE)) begin
                mode_reg <= avs_writedata[2:0];
            end
        end
    end

    assign sic_eff = sic_reg[`SYNC_MODE_ENABLE_BIT] ? sic_reg : 8'h00;
    assign soc_eff = sic_reg[`SYNC_MODE_ENABLE_BIT] ? soc_reg : 8'h00;
    assign echo    = mode_reg[`MODE_ECHO_BIT];
    assign loop    = mode_reg[`MODE_LOOP_BIT];
    assign one_x   = mode_reg[`MODE_CD_BIT];

    baud_divider #(
        .WIDTH (DIV_WIDTH)
    ) u_divider (
        .clock   (clock),
        .sys_rst (sys_rst),
        .divisor (div_reg),
        .load    (load_reg),
        .tick    (brg_tick),
        .level   (brg_level),
        .running (brg_running)
    );

    assign bit_tick = brg_tick && (one_x || presc_reg == `PRESC_LAST);
    assign bclk     = one_x ? brg_level : presc_reg[3];

    always_ff @(posedge clock) begin
        if (sys_rst || load_reg) begin
            presc_reg <= 4'h0;
        end else if (brg_tick) begin
            presc_reg <= presc_reg + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bclk_q_reg <= 1'b0;
        end else begin
            bclk_q_reg <= bclk;
        end
    end

    // A write while a frame is pending replaces the byte
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_data_reg <= 8'h00;
            tx_pend_reg <= 1'b0;
        end else if (wr_ok && hit(idx, `IDX_TX_DATA)) begin
            tx_data_reg <= avs_writedata[7:0];
            tx_pend_reg <= 1'b1;
        end else if (bit_tick && tx_state_reg == sio_pkg::TX_IDLE) begin
            tx_pend_reg <= 1'b0;
        end
    end

    assign busy = tx_state_reg == sio_pkg::TX_SEND;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_state_reg <= sio_pkg::TX_IDLE;
            tx_shift_reg <= 8'h00;
            tx_count_reg <= 3'h0;
        end else if (bit_tick) begin
            unique case (tx_state_reg)
                sio_pkg::TX_IDLE: begin
                    if (tx_pend_reg) begin
                        tx_state_reg <= sio_pkg::TX_SEND;
                        tx_shift_reg <= tx_data_reg;
                        tx_count_reg <= 3'h0;
                    end
                end
                sio_pkg::TX_SEND: begin
                    tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
                    tx_count_reg <= tx_count_reg + 3'h1;
                    if (tx_count_reg == `FRAME_LAST_BIT) begin
                        tx_state_reg <= sio_pkg::TX_IDLE;
                    end
                end
                default: tx_state_reg <= sio_pkg::TX_IDLE;
            endcase
        end
    end

    pin_sync #(
        .WIDTH (3)
    ) u_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in ({carrier_gate_in, receive_clock_in, serial_data_in}),
        .filtered (pins)
    );

    assign sin_eff     = sic_eff[`INPUT_BLOCK_BIT] ? 1'b1 : pins[0];
    assign rxc_eff     = sic_eff[`INPUT_BLOCK_BIT] ? 1'b0 : pins[1];
    assign gate_active = !sic_eff[`INPUT_BLOCK_BIT] && (pins[2] == sic_eff[`CARRIER_GATE_POL_BIT]);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rxc_q_reg <= 1'b0;
        end else begin
            rxc_q_reg <= pins[1];
        end
    end

    // sample edge select
    // Edges come from the pin itself, so setting or clearing the block cannot fake one
    assign ext_edge = !sic_eff[`INPUT_BLOCK_BIT]
                      && (sic_eff[`RX_CLOCK_EDGE_BIT] ? (rxc_q_reg && !pins[1]) : (!rxc_q_reg && pins[1]));
    // loopback feeds receiver from the transmit shifter
    assign rx_edge = loop ? (busy && bclk && !bclk_q_reg)
                          : (ext_edge && (!sic_eff[`CARRIER_GATE_EN_BIT] || gate_active));
    assign rx_bit  = loop ? tx_shift_reg[0] : (sin_eff ^ sic_eff[`INPUT_INVERT_BIT]);

    // Partial byte is dropped once the gate closes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_shift_reg <= 8'h00;
            rx_count_reg <= 3'h0;
            rx_data_reg  <= 8'h00;
        end else if (rx_edge) begin
            rx_shift_reg <= {rx_bit, rx_shift_reg[7:1]};
            rx_count_reg <= rx_count_reg + 3'h1;
            if (rx_count_reg == `FRAME_LAST_BIT) begin
                rx_data_reg <= {rx_bit, rx_shift_reg[7:1]};
            end
        end else if (!loop && sic_eff[`CARRIER_GATE_EN_BIT] && !gate_active) begin
            rx_count_reg <= 3'h0;
        end
    end

    // A new byte in the same cycle as the read keeps the flag set
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_ready_reg <= 1'b0;
        end else if (rx_edge && rx_count_reg == `FRAME_LAST_BIT) begin
            rx_ready_reg <= 1'b1;
        end else if (rd_ok && hit(idx, `IDX_RX_DATA)) begin
            rx_ready_reg <= 1'b0;
        end
    end

    assign frame_act = soc_eff[`FRAME_SIGNAL_BIT] && busy;

    always_comb begin
        if (loop) begin
            serial_data_out_next = 1'b1;
        end else if (echo) begin
            serial_data_out_next = sin_eff;
        end else if (busy) begin
            serial_data_out_next = tx_shift_reg[0] ^ soc_eff[`OUTPUT_INVERT_BIT];
        end else begin
            serial_data_out_next = !soc_eff[`OUTPUT_IDLE_BIT];
        end
        if (echo) begin
            clk_next = rxc_eff;
        end else if (busy) begin
            clk_next = bclk ^ soc_eff[`TX_CLOCK_EDGE_BIT];
        end else begin
            clk_next = !soc_eff[`TX_CLOCK_IDLE_BIT];
        end
        if (echo) begin
            req_next = sic_eff[`INPUT_BLOCK_BIT] ? 1'b0 : pins[2];
        end else if (loop) begin
            req_next = frame_act;
        end else begin
            req_next = soc_eff[`REQUEST_POL_BIT] ? frame_act : !frame_act;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            serial_data_out    <= 1'b1;
            serial_clock_out   <= 1'b1;
            request_out        <= 1'b1;
            frame_start_strobe <= 1'b0;
        end else begin
            serial_data_out    <= serial_data_out_next;
            serial_clock_out   <= clk_next;
            request_out        <= req_next;
            frame_start_strobe <= frame_act && !echo && tx_count_reg == 3'h0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            serial_data_out_oe_n  <= 1'b0;
            serial_clock_out_oe_n <= 1'b0;
            request_out_oe_n      <= 1'b0;
        end else begin
            serial_data_out_oe_n  <= soc_eff[`OUTPUT_TRISTATE_BIT];
            serial_clock_out_oe_n <= soc_eff[`OUTPUT_TRISTATE_BIT];
            request_out_oe_n      <= soc_eff[`OUTPUT_TRISTATE_BIT];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_div_stop;
        (div_reg < DIV_WIDTH'(`DIV_MIN)) |-> !brg_tick && !bit_tick;
    endproperty
    a_div_stop: assert property (p_div_stop) else $error("generator ran below two");

    property p_sync_off;
        (!sic_reg[`SYNC_MODE_ENABLE_BIT] && !echo && !loop && !busy)
            |=> serial_data_out && serial_clock_out && request_out && !serial_data_out_oe_n;
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("settings used with sync off");

    property p_echo_data;
        (echo && !loop) |=> serial_data_out == $past(sin_eff);
    endproperty
    a_echo_data: assert property (p_echo_data) else $error("echo data wrong");

    property p_loop_high;
        loop |=> serial_data_out;
    endproperty
    a_loop_high: assert property (p_loop_high) else $error("loopback output not high");

    property p_tristate;
        soc_eff[`OUTPUT_TRISTATE_BIT] |=> serial_data_out_oe_n && serial_clock_out_oe_n && request_out_oe_n;
    endproperty
    a_tristate: assert property (p_tristate) else $error("outputs not floated");

    property p_strobe;
        frame_start_strobe |-> $past(busy && tx_count_reg == 3'h0);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe outside first bit");

    property p_request;
        (frame_act && !echo && !loop) |=> request_out == $past(soc_eff[`REQUEST_POL_BIT]);
    endproperty
    a_request: assert property (p_request) else $error("request not active in frame");

    property p_idle_low;
        (!echo && !loop && !busy && soc_eff[`OUTPUT_IDLE_BIT]) |=> !serial_data_out;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("idle level wrong");

    property p_block;
        (sic_eff[`INPUT_BLOCK_BIT] && !loop) |-> !rx_edge;
    endproperty
    a_block: assert property (p_block) else $error("blocked input clocked receiver");

    property p_rx_byte;
        (rx_edge && rx_count_reg == `FRAME_LAST_BIT) |=> rx_ready_reg && rx_data_reg == $past({rx_bit, rx_shift_reg[7:1]});
    endproperty
    a_rx_byte: assert property (p_rx_byte) else $error("received byte lost");

    c_frame: cover property (frame_start_strobe ##1 !frame_start_strobe);
    c_echo: cover property (echo && !loop && rx_edge);
    c_rx_byte: cover property (rx_edge && rx_count_reg == `FRAME_LAST_BIT);
endmodule

/* hdl/sio_defines.svh */
`ifndef SIO_DEFINES_SVH
`define SIO_DEFINES_SVH
`define IDX_MODE             8'hf8
`define IDX_TX_DATA          8'hf9
`define IDX_RX_DATA          8'hfa
`define IDX_STATUS           8'hfb
`define IDX_DIV_HIGH         8'hfc
`define IDX_DIV_LOW          8'hfd
`define IDX_SIC              8'hfe
`define IDX_SOC              8'hff
`define SIC_RESET            8'h03
`define SOC_RESET            8'h01
`define SIC_FIXED_MASK       8'h03
`define SOC_FIXED_MASK       8'h01
`define MODE_RESET           3'h0
`define DIV_RESET            16'h0000
`define DIV_MIN              16'h0002
`define SYNC_MODE_ENABLE_BIT 7
`define INPUT_INVERT_BIT     6
`define RX_CLOCK_EDGE_BIT    5
`define CARRIER_GATE_EN_BIT  4
`define CARRIER_GATE_POL_BIT 3
`define INPUT_BLOCK_BIT      2
`define OUTPUT_INVERT_BIT    7
`define OUTPUT_IDLE_BIT      6
`define TX_CLOCK_EDGE_BIT    5
`define TX_CLOCK_IDLE_BIT    4
`define FRAME_SIGNAL_BIT     3
`define REQUEST_POL_BIT      2
`define OUTPUT_TRISTATE_BIT  1
`define MODE_ECHO_BIT        0
`define MODE_LOOP_BIT        1
`define MODE_CD_BIT          2
`define PRESC_LAST           4'hf
`define FRAME_LAST_BIT       3'h7
`endif

/* hdl/sio_pkg.sv */
package sio_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } tx_state_t;
    typedef logic [7:0] byte_t;
endpackage

/* hdl/pin_sync.sv */
module pin_sync #(
    parameter int unsigned WIDTH = 3
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] filtered
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // A change is taken only once the last two stages agree
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            filtered <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    filtered[i] <= stage3_reg[i];
                end
            end
        end
    end
endmodule

/* hdl/baud_divider.sv */
`include "sio_defines.svh"
module baud_divider #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] divisor,
    input  wire logic             load,
    output logic                  tick,
    output logic                  level,
    output logic                  running
);
    logic [WIDTH-1:0] count_reg;

    assign running = divisor >= WIDTH'(`DIV_MIN);
    assign tick    = running && count_reg == WIDTH'(1);
    // Low in the first half of each period, high in the second
    assign level   = count_reg <= (divisor >> 1);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_reg <= '0;
        end else if (load || !running || count_reg <= WIDTH'(1)) begin
            count_reg <= divisor;
        end else begin
            count_reg <= count_reg - WIDTH'(1);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_reload;
        load |=> count_reg == $past(divisor);
    endproperty
    a_reload: assert property (p_reload) else $error("divisor not loaded at once");

    property p_period;
        (tick && !load) ##1 (divisor == $past(divisor) && !load) [*2] |-> count_reg == divisor - WIDTH'(1);
    endproperty
    a_period: assert property (p_period) else $error("divider period wrong");
endmodule

/* sim/sync_peer_model.sv */
module sync_peer_model (
    input  wire logic       clock,
    input  wire logic       serial_data_out,
    input  wire logic       serial_clock_out,
    input  wire logic       request_out,
    input  wire logic       frame_start_strobe,
    output logic            receive_clock_in,
    output logic            serial_data_in,
    output logic            carrier_gate_in,
    output logic [7:0]      got_byte,
    output logic [7:0]      got_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_q;
    initial begin
        receive_clock_in = 1'b0;
        serial_data_in   = 1'b1;
        carrier_gate_in  = 1'b0;
        got_byte         = 8'h00;
        got_strobe       = 8'h00;
        clk_q            = 1'b1;
    end
    always @(posedge clock) begin
        clk_q <= serial_clock_out;
        if (serial_clock_out && !clk_q && request_out) begin
            got_byte   <= {serial_data_out, got_byte[7:1]};
            got_strobe <= {frame_start_strobe, got_strobe[7:1]};
        end
    end
    task automatic send_byte(input logic [7:0] b);
        carrier_gate_in <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            serial_data_in <= b[i];
            repeat (8) @(posedge clock);
            receive_clock_in <= 1'b1;
            repeat (8) @(posedge clock);
            receive_clock_in <= 1'b0;
        end
        repeat (8) @(posedge clock);
        // Released line: show the inverse so a stale value cannot pass
        carrier_gate_in <= 1'b0;
        serial_data_in  <= ~b[7];
    endtask
endmodule

/* sim/serial_sync_io_control_brg_tb.sv */
module serial_sync_io_control_brg_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [9:0]  avs_address = 10'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        sdi, rck, gate, sdo, sdo_oe_n, sck, sck_oe_n, req, req_oe_n, stb;
    logic [7:0]  got_byte, got_strobe;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    initial forever #25 clock = ~clock;
    serial_sync_io_control_brg serial_sync_io_control_brg_i (.clock(clock), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .serial_data_in(sdi),
        .receive_clock_in(rck), .carrier_gate_in(gate), .serial_data_out(sdo), .serial_data_out_oe_n(sdo_oe_n),
        .serial_clock_out(sck), .serial_clock_out_oe_n(sck_oe_n), .request_out(req),
        .request_out_oe_n(req_oe_n), .frame_start_strobe(stb));
    sync_peer_model sync_peer_model_i (.clock(clock), .serial_data_out(sdo), .serial_clock_out(sck),
        .request_out(req), .frame_start_strobe(stb), .receive_clock_in(rck), .serial_data_in(sdi),
        .carrier_gate_in(gate), .got_byte(got_byte), .got_strobe(got_strobe));
    task complete_run;
        $display("Counts: miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Ceiling well above the several hundred cycles the scenarios need
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus_wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clock);
        avs_address   <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write     <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] idx, output logic [31:0] d);
        @(posedge clock);
        avs_address <= {idx, 2'b00};
        avs_read    <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] d;
        bus_rd(idx, d);
        chk(n, e, d);
    endtask
    task automatic test_registers;
        logic [31:0] d;
        rd_chk("sic_reset", 8'hfe, 32'h03);
        rd_chk("soc_reset", 8'hff, 32'h01);
        rd_chk("div_low_reset", 8'hfd, 32'h00);
        bus_wr(8'h10, 8'h5a);
        rd_chk("unmapped", 8'h10, 32'h00);
        bus_wr(8'hfe, 8'h00);
        rd_chk("sic_fixed", 8'hfe, 32'h03);
        bus_wr(8'hff, 8'h00);
        rd_chk("soc_fixed", 8'hff, 32'h01);
        bus_rd(8'hfb, d);
        chk("gen_run_reset", 32'h0, {31'h0, d[2]});
        bus_wr(8'hfd, 8'h01);
        bus_rd(8'hfb, d);
        chk("gen_run_div1", 32'h0, {31'h0, d[2]});
        bus_wr(8'hfd, 8'h02);
        bus_rd(8'hfb, d);
        chk("gen_run_div2", 32'h1, {31'h0, d[2]});
    endtask
    task automatic test_transmit(input logic [7:0] soc, input logic [7:0] b, input logic [7:0] e);
        bus_wr(8'hfe, 8'h80);
        bus_wr(8'hff, soc);
        bus_wr(8'hf8, 8'h04);
        bus_wr(8'hfc, 8'h00);
        bus_wr(8'hfd, 8'h04);
        bus_wr(8'hf9, b);
        do @(posedge clock); while (req !== 1'b1);
        do @(posedge clock); while (req !== 1'b0);
        repeat (2) @(posedge clock);
        chk("tx_byte", {24'h0, e}, {24'h0, got_byte});
        chk("tx_strobe", 32'h01, {24'h0, got_strobe});
        chk("tx_idle_clock", 32'h1, {31'h0, sck});
    endtask
    task automatic test_receive;
        logic [31:0] d;
        bus_wr(8'hfe, 8'hd8);
        sync_peer_model_i.send_byte(8'h5a);
        repeat (6) @(posedge clock);
        rd_chk("rx_ready", 8'hfb, 32'h02 | {29'h0, 1'b1, 2'b0});
        rd_chk("rx_data", 8'hfa, 32'ha5);
        bus_wr(8'hfe, 8'hdc);
        sync_peer_model_i.send_byte(8'h11);
        repeat (6) @(posedge clock);
        bus_rd(8'hfb, d);
        chk("rx_blocked", 32'h0, {31'h0, d[1]});
    endtask
    task automatic test_pins;
        bus_wr(8'hfe, 8'h00);
        bus_wr(8'hff, 8'h40);
        repeat (3) @(posedge clock);
        chk("idle_sync_off", 32'h1, {31'h0, sdo});
        bus_wr(8'hfe, 8'h80);
        repeat (3) @(posedge clock);
        chk("idle_low", 32'h0, {31'h0, sdo});
        bus_wr(8'hff, 8'h02);
        repeat (3) @(posedge clock);
        chk("tristate", 32'h7, {29'h0, sdo_oe_n, sck_oe_n, req_oe_n});
    endtask
    // Idle pins differ from what echo and loopback must show, so each check can fail
    task automatic test_modes;
        logic [31:0] d;
        bus_wr(8'hfe, 8'hc0);
        bus_wr(8'hff, 8'hc0);
        bus_wr(8'hf8, 8'h01);
        repeat (3) @(posedge clock);
        chk("echo_data", 32'h1, {31'h0, sdo});
        chk("echo_clock", 32'h0, {31'h0, sck});
        chk("echo_request", 32'h0, {31'h0, req});
        bus_wr(8'hf8, 8'h06);
        repeat (3) @(posedge clock);
        chk("loop_high", 32'h1, {31'h0, sdo});
        bus_wr(8'hf9, 8'h96);
        do bus_rd(8'hfb, d); while (d[1] !== 1'b1);
        rd_chk("loop_data", 8'hfa, 32'h96);
    endtask
    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        test_registers();
        test_transmit(8'h0c, 8'ha5, 8'ha5);
        test_transmit(8'h8c, 8'h3c, 8'hc3);
        test_receive();
        test_pins();
        test_modes();
        complete_run();
    end
endmodule
